/* shared/tmr_map.svh */
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL 8'h88
`define IDX_MODE 8'h89
`define IDX_LO_A 8'h8A
`define IDX_HI_A 8'h8B
`define IDX_LO_B 8'h8C
`define IDX_HI_B 8'h8D

// Reset values
`define CTRL_RST 8'h00
`define MODE_RST 8'h00

// Control register fields
`define OVF_B 7
`define RUN_B 6
`define OVF_A 5
`define RUN_A 4
`define EIF_B 3
`define EIT_B 2
`define EIF_A 1
`define EIT_A 0

// Mode register fields
`define GATE_B 7
`define SRC_B 6
`define MODE_B_HI 5
`define MODE_B_LO 4
`define GATE_A 3
`define SRC_A 2
`define MODE_A_HI 1
`define MODE_A_LO 0

// Machine cycle: six oscillator periods
`define MCYC_LAST 3'h5

`endif

/* shared/tmr_pkg.sv */
`default_nettype none

package tmr_pkg;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // Counter arrangement per timer
    typedef enum logic [1:0] {
        MODE_13,
        MODE_16,
        MODE_RELOAD,
        MODE_SPLIT
    } mode_t;

    // Bus answer sequencing
    typedef enum logic {
        ST_IDLE,
        ST_DONE
    } bus_st_t;

endpackage

`default_nettype wire

/* logic/dual_timer.sv */
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"

// Summary of operation
// - Two mode bits per timer choose 13-bit, 16-bit, reload or split arrangement.
// - Mode 0 counts high byte plus low five bits as a prescaler.
// - Upper three low-byte bits are undefined in mode 0; software ignores them.
// - Wrapping from all ones to zero sets that timer's overflow flag.
// - Counting runs only with run bit set and gate clear or pin high; timer 1 ignores its run bit while timer 0 is split.
// - Setting a run bit never clears the count registers.
// - Gate bits sit at mode bit 7 for timer 1, bit 3 for timer 0.
// - Mode 1 cascades both bytes into one 16-bit counter, no prescaler.
// - Mode 2 low byte overflow sets flag and reloads it from high byte.
// - Timer 1 in mode 3 holds its count as if stopped.
// - Split timer 0 low byte uses timer 0 controls and interrupt pin.
// - Split timer 0 high byte counts cycles under timer 1 run and flag.
// - Timer 1 stops in its mode 3; while timer 0 is split its overflow still feeds baud tick.
// - Overflow flags at bits 7,5 clear on vector acknowledge or zero write.
// - Interrupt flags at bits 3,1 set on edge or low level, clear likewise.
// - Type bits 2 and 0 select falling edge or low level triggering.
// - Reset clears the control register, timers stopped, flags clear.
// - Timer function advances once per machine cycle of six clocks.
// - Counter function advances one machine cycle after a sampled fall.
module dual_timer (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Register bus
    input wire tmr_pkg::apb_req_t apb_req,
    output var tmr_pkg::apb_rsp_t apb_rsp,
    // Device pins
    input wire logic count_pin_a,
    input wire logic count_pin_b,
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    // Interrupt vector acknowledges from the core
    input wire logic ack_ovf_a,
    input wire logic ack_ovf_b,
    input wire logic ack_ext_a,
    input wire logic ack_ext_b,
    // Status toward core and serial port
    output var logic [3:0] irq_req,
    output var logic baud_tick
);
    import tmr_pkg::*;

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] mode_reg;
    logic [7:0] lo_reg [2];
    logic [7:0] hi_reg [2];
    logic [7:0] lo_next [2];
    logic [7:0] hi_next [2];
    bus_st_t st_reg;
    logic [2:0] div_reg;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [1:0] irq_prev_reg;
    logic [1:0] samp_reg;
    logic [1:0] fall_reg;
    logic mtick;
    logic [7:0] idx;
    logic hit;
    logic take;
    logic wr_ctrl;
    logic wr_mode;
    logic [31:0] rd_val;
    mode_t mode_a;
    mode_t mode_b;
    logic split_a;
    logic en_a;
    logic en_b;
    logic inc_a;
    logic inc_b;
    logic inc_hi_a;
    logic ovf_a_evt;
    logic ovf_b_evt;
    logic t1_ovf;
    logic hi_ovf;
    logic [1:0] irq_pin;
    logic [1:0] ext_set;
    logic [16:0] step_a;
    logic [16:0] step_b;
    logic [8:0] hi_sum;

    // Synced pins: [3] irq b, [2] irq a, [1] count b, [0] count a
    assign irq_pin = sync2_reg[3:2];

    // Increment one timer by its arrangement; returns {carry, hi, lo}
    function automatic logic [16:0] step(input mode_t m, input logic [7:0] lo,
                                         input logic [7:0] hi);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        logic [16:0] r;
        s13 = {1'b0, hi, lo[4:0]} + 14'h1;
        s16 = {1'b0, hi, lo} + 17'h1;
        s8 = {1'b0, lo} + 9'h1;
        case (m)
            // top three low bits left as they are
            MODE_13: r = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
            MODE_16: r = s16;
            // reload low byte from high byte
            MODE_RELOAD: r = {s8[8], hi, s8[8] ? hi : s8[7:0]};
            default: r = {s8[8], hi, s8[7:0]};
        endcase
        return r;
    endfunction

    // Two-stage synchronisers for every pin
    // They reset to the idle high level, so no false low reaches the flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 4'hF;
            sync2_reg <= 4'hF;
        end else if (clk_en) begin
            sync1_reg <= {ext_irq_pin_b, ext_irq_pin_a, count_pin_b, count_pin_a};
            sync2_reg <= sync1_reg;
        end
    end

    // Machine cycle divider; everything counts on mtick
    // one tick per six clocks
    assign mtick = clk_en && (div_reg == `MCYC_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 3'h0;
        end else if (clk_en) begin
            div_reg <= mtick ? 3'h0 : div_reg + 3'h1;
        end
    end

    // Count pins sampled once per machine cycle; the fall is held one cycle
    // sampled fall counts next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_reg <= 2'h0;
            fall_reg <= 2'h0;
        end else if (mtick) begin
            samp_reg <= sync2_reg[1:0];
            fall_reg <= samp_reg & ~sync2_reg[1:0];
        end
    end

    // Interrupt pin history for falling edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_prev_reg <= 2'h3;
        end else if (clk_en) begin
            irq_prev_reg <= irq_pin;
        end
    end

    assign mode_a = mode_t'(mode_reg[`MODE_A_HI:`MODE_A_LO]);
    assign mode_b = mode_t'(mode_reg[`MODE_B_HI:`MODE_B_LO]);
    assign split_a = (mode_a == MODE_SPLIT);

    // Count enables
    // run and gate qualify counting
    // split low byte keeps timer 0 controls
    assign en_a = ctrl_reg[`RUN_A] && (!mode_reg[`GATE_A] || irq_pin[0]);
    // mode 3 stops timer 1 like a cleared run bit
    // leaving mode 3 restarts it
    // Split timer 0 owns run_b, so then only mode 3 and the gate start and stop timer 1
    assign en_b = (ctrl_reg[`RUN_B] || split_a) && (!mode_reg[`GATE_B] || irq_pin[1])
                  && (mode_b != MODE_SPLIT);
    assign inc_a = en_a && mtick && (mode_reg[`SRC_A] ? fall_reg[0] : 1'b1);
    assign inc_b = en_b && mtick && (mode_reg[`SRC_B] ? fall_reg[1] : 1'b1);
    // split high byte counts cycles under timer 1 run bit
    assign inc_hi_a = split_a && ctrl_reg[`RUN_B] && mtick;

    // Next counter values; a bus write to a byte overrides the count
    always_comb begin
        step_a = step(mode_a, lo_reg[0], hi_reg[0]);
        step_b = step(mode_b, lo_reg[1], hi_reg[1]);
        hi_sum = {1'b0, hi_reg[0]} + 9'h1;
        lo_next[0] = lo_reg[0];
        hi_next[0] = hi_reg[0];
        lo_next[1] = lo_reg[1];
        hi_next[1] = hi_reg[1];
        ovf_a_evt = 1'b0;
        t1_ovf = 1'b0;
        hi_ovf = 1'b0;
        if (inc_a) begin
            ovf_a_evt = step_a[16];
            lo_next[0] = step_a[7:0];
            if (!split_a) begin
                hi_next[0] = step_a[15:8];
            end
        end
        if (inc_hi_a) begin
            hi_ovf = hi_sum[8];
            hi_next[0] = hi_sum[7:0];
        end
        if (inc_b) begin
            t1_ovf = step_b[16];
            lo_next[1] = step_b[7:0];
            hi_next[1] = step_b[15:8];
        end
        if (take && apb_req.pwrite) begin
            if (idx == `IDX_LO_A) lo_next[0] = apb_req.pwdata[7:0];
            if (idx == `IDX_HI_A) hi_next[0] = apb_req.pwdata[7:0];
            if (idx == `IDX_LO_B) lo_next[1] = apb_req.pwdata[7:0];
            if (idx == `IDX_HI_B) hi_next[1] = apb_req.pwdata[7:0];
        end
    end

    // split high byte takes over timer 1 overflow flag
    assign ovf_b_evt = split_a ? hi_ovf : t1_ovf;

    // Count registers; reset clears, run bit writes never touch them
    // counts only change by counting or direct write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_reg[0] <= 8'h00;
            hi_reg[0] <= 8'h00;
            lo_reg[1] <= 8'h00;
            hi_reg[1] <= 8'h00;
        end else if (clk_en) begin
            lo_reg[0] <= lo_next[0];
            hi_reg[0] <= hi_next[0];
            lo_reg[1] <= lo_next[1];
            hi_reg[1] <= hi_next[1];
        end
    end

    // External interrupt detection: type bit set means falling edge
    // edge or level select
    assign ext_set[0] = ctrl_reg[`EIT_A] ? (irq_prev_reg[0] && !irq_pin[0]) : !irq_pin[0];
    assign ext_set[1] = ctrl_reg[`EIT_B] ? (irq_prev_reg[1] && !irq_pin[1]) : !irq_pin[1];

    // Control next value: write, then acknowledge clears, then hardware sets
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = apb_req.pwdata[7:0];
        end
        if (ack_ovf_a) ctrl_next[`OVF_A] = 1'b0;
        if (ack_ovf_b) ctrl_next[`OVF_B] = 1'b0;
        if (ack_ext_a) ctrl_next[`EIF_A] = 1'b0;
        if (ack_ext_b) ctrl_next[`EIF_B] = 1'b0;
        // A set in the same cycle as a clear wins, so no event is lost
        if (ovf_a_evt) ctrl_next[`OVF_A] = 1'b1;
        if (ovf_b_evt) ctrl_next[`OVF_B] = 1'b1;
        // edge or low level sets flag
        if (ext_set[0]) ctrl_next[`EIF_A] = 1'b1;
        if (ext_set[1]) ctrl_next[`EIF_B] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTRL_RST;
        end else if (clk_en) begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Mode register, software only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= `MODE_RST;
        end else if (wr_mode) begin
            mode_reg <= apb_req.pwdata[7:0];
        end
    end

    // Flags to the core and timer 1 overflow pulse for the serial port
    assign irq_req = {ctrl_reg[`OVF_B], ctrl_reg[`OVF_A], ctrl_reg[`EIF_B],
                      ctrl_reg[`EIF_A]};

    // baud pulse follows timer 1 even when split takes its flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_tick <= 1'b0;
        end else if (clk_en) begin
            baud_tick <= t1_ovf;
        end
    end

    // Bus decode: word aligned, index in paddr[9:2]
    assign idx = apb_req.paddr[9:2];
    assign hit = (apb_req.paddr[11:10] == 2'h0) && (apb_req.paddr[1:0] == 2'h0)
                 && (idx >= `IDX_CTRL) && (idx <= `IDX_HI_B);
    // The write lands on the edge where the master sees pready
    assign take = clk_en && (st_reg == ST_DONE) && apb_req.psel && apb_req.penable
                  && hit;
    assign wr_ctrl = take && apb_req.pwrite && (idx == `IDX_CTRL);
    assign wr_mode = take && apb_req.pwrite && (idx == `IDX_MODE);

    // Read mux; narrow registers sit in the low byte
    always_comb begin
        rd_val = 32'h0;
        case (idx)
            `IDX_CTRL: rd_val[7:0] = ctrl_reg;
            `IDX_MODE: rd_val[7:0] = mode_reg;
            `IDX_LO_A: rd_val[7:0] = lo_reg[0];
            `IDX_HI_A: rd_val[7:0] = hi_reg[0];
            `IDX_LO_B: rd_val[7:0] = lo_reg[1];
            `IDX_HI_B: rd_val[7:0] = hi_reg[1];
            default: rd_val = 32'h0;
        endcase
    end

    // Answer one cycle into the access phase; unmapped gives pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_IDLE;
            apb_rsp <= '0;
        end else if (clk_en) begin
            case (st_reg)
                ST_IDLE: begin
                    if (apb_req.psel && apb_req.penable) begin
                        apb_rsp.pready <= 1'b1;
                        apb_rsp.pslverr <= !hit;
                        apb_rsp.prdata <= hit ? rd_val : 32'h0;
                        st_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    apb_rsp <= '0;
                    st_reg <= ST_IDLE;
                end
                default: begin
                    apb_rsp <= '0;
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Checks on the timer behaviour
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_quiet;
        !mtick[*5];
    endsequence

    a_reset_ctrl_zero: assert property ($rose(presetn) |-> ctrl_reg == 8'h00)
        else $error("control not clear after reset");

    a_mcyc_spacing: assert property (mtick |=> s_quiet)
        else $error("machine cycle shorter than six clocks");

    a_ovf_sets: assert property (clk_en && ovf_a_evt |=> ctrl_reg[`OVF_A])
        else $error("overflow did not set flag a");

    a_gate_holds: assert property (clk_en && mode_reg[`GATE_A] && !irq_pin[0] && !take
        |=> $stable(lo_reg[0]))
        else $error("gated timer a counted");

    a_reload_low: assert property (clk_en && mode_b == MODE_RELOAD && t1_ovf
        && !take |=> lo_reg[1] == hi_reg[1] && $stable(hi_reg[1]))
        else $error("reload did not copy high byte");

    a_t1_mode3_hold: assert property (mode_b == MODE_SPLIT && !take
        |=> $stable(lo_reg[1]) && $stable(hi_reg[1]))
        else $error("timer b moved in mode 3");

    a_split_hi_flag: assert property (clk_en && inc_hi_a && hi_reg[0] == 8'hFF
        |=> ctrl_reg[`OVF_B] && hi_reg[0] == 8'h00)
        else $error("split high overflow lost");

    a_ack_clears: assert property (clk_en && ack_ovf_a && !ovf_a_evt && !wr_ctrl
        |=> !ctrl_reg[`OVF_A])
        else $error("acknowledge did not clear flag a");

    a_edge_flag: assert property (clk_en && ctrl_reg[`EIT_B] && irq_prev_reg[1]
        && !irq_pin[1] |=> ctrl_reg[`EIF_B])
        else $error("falling edge missed on irq b");

    a_run_keeps: assert property ($rose(ctrl_reg[`RUN_A]) && !$past(split_a)
        |-> $stable(lo_reg[0]) && $stable(hi_reg[0]))
        else $error("run bit changed count");

endmodule

`default_nettype wire

/* bench/core_model.sv */
`timescale 1ns/1ps
`default_nettype none

module core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Requests seen and vectors the bench lets through
    input wire logic [3:0] irq_req,
    input wire logic [3:0] accept,
    // Vector acknowledges
    output logic ack_ovf_a,
    output logic ack_ovf_b,
    output logic ack_ext_a,
    output logic ack_ext_b
);
    logic [3:0] ack;

    // vectoring clears flags
    // One pulse per taken vector; the gap stops a second vector on a stale flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack <= 4'h0;
        end else begin
            ack <= irq_req & accept & ~ack;
        end
    end

    // Same bit order as the request vector
    assign {ack_ovf_b, ack_ovf_a, ack_ext_b, ack_ext_a} = ack;
endmodule

`default_nettype wire

/* bench/tb_dual_timer_counter_modes.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"

module tb_dual_timer_counter_modes;
    import tmr_pkg::*;
    // Byte address is four times the register index
    localparam logic [11:0] A_CTRL = {2'b00, `IDX_CTRL, 2'b00};
    localparam logic [11:0] A_MODE = {2'b00, `IDX_MODE, 2'b00};
    localparam logic [11:0] A_LOA = {2'b00, `IDX_LO_A, 2'b00};
    localparam logic [11:0] A_HIA = {2'b00, `IDX_HI_A, 2'b00};
    localparam logic [11:0] A_LOB = {2'b00, `IDX_LO_B, 2'b00};
    localparam logic [11:0] A_HIB = {2'b00, `IDX_HI_B, 2'b00};
    logic pclk, presetn, count_pin_a, count_pin_b, ext_irq_pin_a, ext_irq_pin_b;
    logic ack_ovf_a, ack_ovf_b, ack_ext_a, ack_ext_b, baud_tick, e;
    logic [3:0] irq_req, accept;
    logic [7:0] q;
    apb_req_t req;
    apb_rsp_t rsp;
    int err_count = 0;
    int checks = 0;
    int ticks = 0;
    int t0;

    dual_timer i_dual_timer (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .apb_req(req), .apb_rsp(rsp),
        .count_pin_a(count_pin_a), .count_pin_b(count_pin_b),
        .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b),
        .ack_ovf_a(ack_ovf_a), .ack_ovf_b(ack_ovf_b),
        .ack_ext_a(ack_ext_a), .ack_ext_b(ack_ext_b),
        .irq_req(irq_req), .baud_tick(baud_tick)
    );

    core_model i_core_model (
        .pclk(pclk), .presetn(presetn), .irq_req(irq_req), .accept(accept),
        .ack_ovf_a(ack_ovf_a), .ack_ovf_b(ack_ovf_b),
        .ack_ext_a(ack_ext_a), .ack_ext_b(ack_ext_b)
    );

    // Free running 125 MHz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Count baud pulses toward the serial port
    always @(posedge pclk) begin
        if (baud_tick === 1'b1) begin
            ticks <= ticks + 1;
        end
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One APB transfer; read data and error are taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= {24'h000000, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (rsp.pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        // Values read here are those standing at this rising edge
        q = rsp.prdata[7:0];
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (rsp.pready !== 1'b1) begin
            err_count++;
            $display("Error apb_wait expected ready seen none");
            end_of_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] x,
                      input logic [7:0] m = 8'hFF);
        apb(1'b0, a, 8'h00);
        chk(nm, {8'h00, q & m}, {8'h00, x});
    endtask

    // A pin fall held well over one machine cycle each level
    task automatic fall(input logic b);
        @(posedge pclk);
        if (b)
            count_pin_b <= 1'b0;
        else
            count_pin_a <= 1'b0;
        repeat (18) @(posedge pclk);
        count_pin_a <= 1'b1;
        count_pin_b <= 1'b1;
        repeat (18) @(posedge pclk);
    endtask

    // Let the core take one vector and see its request drop
    task automatic vec(input int i);
        int n;
        @(posedge pclk);
        accept <= 4'h1 << i;
        for (n = 0; n < 10 && irq_req[i] !== 1'b0; n++) begin
            @(negedge pclk);
        end
        chk("irq_req", {15'h0000, irq_req[i]}, 16'h0000);
        @(posedge pclk);
        accept <= 4'h0;
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        req = '0;
        accept = 4'h0;
        {count_pin_a, count_pin_b, ext_irq_pin_a, ext_irq_pin_b} = 4'hF;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rc("ctrl", A_CTRL, 8'h00);
        apb(1'b0, 12'h238, 8'h00);
        chk("unmapped_err", {15'h0000, e}, 16'h0001);
        apb(1'b1, 12'h221, 8'h55);
        chk("misaligned_err", {15'h0000, e}, 16'h0001);
        wr(A_MODE, 8'h88);
        rc("mode", A_MODE, 8'h88);
        $display("test reset_map done");
        // Gated timer with level interrupt on the gate pin
        wr(A_MODE, 8'h09);
        ext_irq_pin_a <= 1'b0;
        wr(A_CTRL, 8'h10);
        repeat (60) @(posedge pclk);
        rc("lo_a_gated", A_LOA, 8'h00);
        rc("ctrl_level", A_CTRL, 8'h12);
        wr(A_CTRL, 8'h10);
        rc("ctrl_relevel", A_CTRL, 8'h12);
        ext_irq_pin_a <= 1'b1;
        repeat (10) @(posedge pclk);
        wr(A_CTRL, 8'h10);
        rc("ctrl_sw_clr", A_CTRL, 8'h10);
        wr(A_LOA, 8'h00);
        repeat (120) @(posedge pclk);
        wr(A_CTRL, 8'h00);
        apb(1'b0, A_LOA, 8'h00);
        chk("timer_rate", {15'h0000, q >= 8'h12 && q <= 8'h17}, 16'h0001);
        $display("test gate_timer done");
        // Mode 1 counter across the 16-bit wrap
        wr(A_MODE, 8'h05);
        wr(A_LOA, 8'hFE);
        wr(A_HIA, 8'hFF);
        wr(A_CTRL, 8'h10);
        rc("lo_a_kept", A_LOA, 8'hFE);
        repeat (3) fall(1'b0);
        rc("lo_a", A_LOA, 8'h01);
        rc("hi_a", A_HIA, 8'h00);
        rc("ctrl_ovf_a", A_CTRL, 8'h30);
        vec(2);
        rc("ctrl_acked", A_CTRL, 8'h10);
        $display("test mode1 done");
        // Mode 0: five-bit prescaler under the high byte
        wr(A_CTRL, 8'h00);
        wr(A_MODE, 8'h04);
        wr(A_LOA, 8'hFF);
        wr(A_HIA, 8'hFF);
        wr(A_CTRL, 8'h10);
        fall(1'b0);
        rc("m0_lo_wrap", A_LOA, 8'h00, 8'h1F);
        rc("m0_hi_wrap", A_HIA, 8'h00);
        rc("m0_ovf", A_CTRL, 8'h30);
        wr(A_CTRL, 8'h10);
        rc("ovf_sw_clr", A_CTRL, 8'h10);
        wr(A_LOA, 8'h1F);
        wr(A_HIA, 8'h00);
        fall(1'b0);
        rc("m0_hi_carry", A_HIA, 8'h01);
        rc("m0_lo_carry", A_LOA, 8'h00, 8'h1F);
        $display("test mode0 done");
        // Falling edge interrupt on pin b
        wr(A_CTRL, 8'h04);
        @(posedge pclk);
        ext_irq_pin_b <= 1'b0;
        repeat (6) @(posedge pclk);
        ext_irq_pin_b <= 1'b1;
        repeat (6) @(posedge pclk);
        rc("ctrl_edge_b", A_CTRL, 8'h0C);
        vec(1);
        rc("ctrl_edge_clr", A_CTRL, 8'h04);
        $display("test ext_edge done");
        // Mode 2 reload on timer b, then its mode 3 hold
        wr(A_CTRL, 8'h00);
        wr(A_MODE, 8'h60);
        wr(A_HIB, 8'hF0);
        wr(A_LOB, 8'hFF);
        wr(A_CTRL, 8'h40);
        t0 = ticks;
        fall(1'b1);
        rc("lo_b_reload", A_LOB, 8'hF0);
        rc("hi_b_kept", A_HIB, 8'hF0);
        rc("ctrl_ovf_b", A_CTRL, 8'hC0);
        chk("baud_ticks", 16'(ticks - t0), 16'h0001);
        wr(A_MODE, 8'h70);
        fall(1'b1);
        rc("lo_b_held", A_LOB, 8'hF0);
        $display("test reload_hold done");
        // Split timer a: high byte under run_b, low byte under run_a
        wr(A_CTRL, 8'h00);
        wr(A_MODE, 8'h07);
        wr(A_LOA, 8'h10);
        wr(A_HIA, 8'hFE);
        wr(A_CTRL, 8'h40);
        repeat (30) @(posedge pclk);
        rc("split_ovf_b", A_CTRL, 8'hC0);
        rc("split_lo_idle", A_LOA, 8'h10);
        wr(A_CTRL, 8'h50);
        fall(1'b0);
        rc("split_lo_count", A_LOA, 8'h11);
        $display("test split done");
        end_of_test();
    end
endmodule

`default_nettype wire
